// ===== design/afd_decoder.sv
/*
 * feature and power command decoder: task-file registers over axi4-lite,
 * set features / set multiple / sleep / standby execution, mode outputs.
 * assumes flush_done and data_reg_access come from logic on aclk.
 */
`timescale 1ns/1ps
// ============================================================================
// Summary of operation
// - command efh runs feature from feature register
// - 01h forces byte lanes, wide indicator held off
// - 81h restores sixteen-bit data register transfers
// - 02h enables write cache, 82h disables it
// - cache disable flushes before command completes
// - 03h sets transfer type and mode number
// - exactly one pio and dma mode always
// - 05h enables, 85h disables advanced power management
// - 09h enables, 89h disables extended power
// - 0ah allows, 8ah forbids power level 1
// - 44h vendor ecc length, bbh four bytes
// - 55h disables, aah enables read look-ahead
// - 66h keeps settings, cch restores soft-reset defaults
// - 69h, 96h, 97h accepted with no effect
// - 9ah records host current capability
// - c6h sets sectors per block, drive bit
// - 99h or e6h enters sleep
// - 96h or e2h enters standby
module afd_decoder #(
  parameter int          ADDR_W    = 8,
  parameter int          MAX_PIO   = 6,
  parameter int          MAX_MDMA  = 4,
  parameter bit          HAS_WCACHE = 1'b1,
  parameter bit          HAS_DMA   = 1'b1,
  parameter bit          DRIVE_SEL = 1'b0
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              data_reg_access,
  input  wire logic              flush_done,
  input  wire logic              soft_reset_req,
  output logic                   wide_io_indicator_n,
  output logic                   eight_bit_mode,
  output logic                   write_cache_on,
  output logic                   flush_req,
  output logic                   apm_on,
  output logic                   ext_power_on,
  output logic                   power_level1_on,
  output logic                   ecc_vendor_len,
  output logic                   look_ahead_on,
  output logic [2:0]             pio_mode,
  output logic [2:0]             mdma_mode,
  output logic [7:0]             host_current,
  output logic [7:0]             multiple_count,
  output logic                   sleep_mode,
  output logic                   standby_mode,
  output logic                   cmd_busy
);
  // ==========================================================================
  // elaboration checks
  if (ADDR_W < 8 || ADDR_W > 32 || MAX_PIO > 7 || MAX_MDMA > 7) begin : gen_param_check
    $error("afd_decoder: unsupported parameter values");
  end

  // ==========================================================================
  // state
  typedef enum logic [1:0] {FSM_IDLE, FSM_EXEC, FSM_FLUSH} afd_fsm_e;

  typedef struct packed {
    logic       awready;
    logic       wready;
    logic       bvalid;
    logic [1:0] bresp;
    logic       arready;
    logic       rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [5:0] awidx;
    logic [7:0] wbyte;
    logic       wlane;
    logic [7:0] feature;
    logic [7:0] seccnt;
    logic [7:0] secnum;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
    logic [7:0] devhead;
    logic [7:0] command;
    afd_fsm_e   fsm;
    logic       busy;
    logic       err;
    logic       abort;
    logic       done;
    logic       flush_req;
    logic       sleep;
    logic       standby;
    logic       wide_io_n;
    logic       eight_bit;
    logic       wcache;
    logic       apm;
    logic       ext_pwr;
    logic       pl1;
    logic       ecc_vendor;
    logic       look_ahead;
    logic       keep;
    logic [2:0] pio;
    logic [2:0] mdma;
    logic [7:0] host_cur;
    logic [7:0] multi;
  } afd_state_s;

  localparam afd_state_s ST_RST = '{awready: 1'b1, wready: 1'b1, arready: 1'b1,
    fsm: FSM_IDLE, wide_io_n: 1'b1, wcache: afd_pkg::RST_WCACHE,
    look_ahead: afd_pkg::RST_LA, pio: afd_pkg::RST_PIO, mdma: afd_pkg::RST_MDMA,
    default: '0};

  afd_state_s st;
  afd_state_s next_st;

  // ==========================================================================
  // functions
  function automatic logic reg_known(input logic [5:0] idx);
    reg_known = (idx >= afd_pkg::IDX_FEATURE) && (idx <= afd_pkg::IDX_MODES);
  endfunction

  function automatic logic [31:0] reg_read(input afd_state_s s, input logic [5:0] idx);
    logic [31:0] v;
    v = '0;
    case (idx)
      afd_pkg::IDX_SECCNT:  v[7:0] = s.seccnt;
      afd_pkg::IDX_SECNUM:  v[7:0] = s.secnum;
      afd_pkg::IDX_CYL_LO:  v[7:0] = s.cyl_lo;
      afd_pkg::IDX_CYL_HI:  v[7:0] = s.cyl_hi;
      afd_pkg::IDX_DEVHEAD: v[7:0] = s.devhead;
      afd_pkg::IDX_STATUS: begin
        v[afd_pkg::ST_BUSY]  = s.busy;
        v[afd_pkg::ST_ERR]   = s.err;
        v[afd_pkg::ST_ABORT] = s.abort;
        v[afd_pkg::ST_DONE]  = s.done;
        v[afd_pkg::ST_FLUSH] = s.flush_req;
        v[afd_pkg::ST_SLEEP] = s.sleep;
        v[afd_pkg::ST_STBY]  = s.standby;
      end
      afd_pkg::IDX_CONFIG: begin
        v[afd_pkg::CF_8BIT] = s.eight_bit;
        v[afd_pkg::CF_WC]   = s.wcache;
        v[afd_pkg::CF_APM]  = s.apm;
        v[afd_pkg::CF_EXT]  = s.ext_pwr;
        v[afd_pkg::CF_PL1]  = s.pl1;
        v[afd_pkg::CF_ECCV] = s.ecc_vendor;
        v[afd_pkg::CF_LA]   = s.look_ahead;
        v[afd_pkg::CF_KEEP] = s.keep;
      end
      afd_pkg::IDX_MODES: begin
        v[afd_pkg::MD_PIO +: 3]   = s.pio;
        v[afd_pkg::MD_MDMA +: 3]  = s.mdma;
        v[afd_pkg::MD_HCUR +: 8]  = s.host_cur;
        v[afd_pkg::MD_MULTI +: 8] = s.multi;
      end
      default: v = '0;
    endcase
    reg_read = v;
  endfunction

  // ==========================================================================
  // next state
  always_comb begin
    next_st = st;
    next_st.wide_io_n = !(data_reg_access && !st.eight_bit);

    // write channels, taken in either order
    if (st.awready && s_axi_awvalid) begin
      next_st.awready = 1'b0;
      next_st.awidx   = s_axi_awaddr[7:2];
    end
    if (st.wready && s_axi_wvalid) begin
      next_st.wready = 1'b0;
      next_st.wbyte  = s_axi_wdata[7:0];
      next_st.wlane  = s_axi_wstrb[0];
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid  = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready  = 1'b1;
    end
    if (!st.awready && !st.wready && !st.bvalid) begin
      next_st.bvalid = 1'b1;
      next_st.bresp  = reg_known(st.awidx) ? afd_pkg::RESP_OKAY : afd_pkg::RESP_SLVERR;
      // task file is frozen while a command runs
      if (st.wlane && !st.busy) begin
        case (st.awidx)
          afd_pkg::IDX_FEATURE: next_st.feature = st.wbyte;
          afd_pkg::IDX_SECCNT:  next_st.seccnt  = st.wbyte;
          afd_pkg::IDX_SECNUM:  next_st.secnum  = st.wbyte;
          afd_pkg::IDX_CYL_LO:  next_st.cyl_lo  = st.wbyte;
          afd_pkg::IDX_CYL_HI:  next_st.cyl_hi  = st.wbyte;
          afd_pkg::IDX_DEVHEAD: next_st.devhead = st.wbyte;
          afd_pkg::IDX_COMMAND: begin
            next_st.command = st.wbyte;
            next_st.busy    = 1'b1;
            next_st.done    = 1'b0;
            next_st.err     = 1'b0;
            next_st.abort   = 1'b0;
            next_st.fsm     = FSM_EXEC;
          end
          default: next_st.fsm = st.fsm;
        endcase
      end
    end

    // read channel
    if (st.arready && s_axi_arvalid) begin
      next_st.arready = 1'b0;
      next_st.rvalid  = 1'b1;
      next_st.rdata   = reg_read(st, s_axi_araddr[7:2]);
      next_st.rresp   = reg_known(s_axi_araddr[7:2]) ? afd_pkg::RESP_OKAY : afd_pkg::RESP_SLVERR;
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid  = 1'b0;
      next_st.arready = 1'b1;
    end

    // command execution
    case (st.fsm)
      FSM_EXEC: begin
        next_st.fsm  = FSM_IDLE;
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
        // another drive's command is dropped without effect
        if (st.devhead[afd_pkg::DRIVE_BIT] != DRIVE_SEL) begin
          next_st.done = 1'b0;
        end else begin
          case (st.command)
            afd_pkg::CMD_SET_FEATURES: begin
              case (st.feature)
                afd_pkg::FEA_8BIT_ON:    next_st.eight_bit = 1'b1;
                afd_pkg::FEA_8BIT_OFF:   next_st.eight_bit = 1'b0;
                afd_pkg::FEA_APM_ON:     next_st.apm = 1'b1;
                afd_pkg::FEA_APM_OFF:    next_st.apm = 1'b0;
                afd_pkg::FEA_EXTPWR_ON:  next_st.ext_pwr = 1'b1;
                afd_pkg::FEA_EXTPWR_OFF: next_st.ext_pwr = 1'b0;
                afd_pkg::FEA_PL1_ON:     next_st.pl1 = 1'b1;
                afd_pkg::FEA_PL1_OFF:    next_st.pl1 = 1'b0;
                afd_pkg::FEA_ECC_VENDOR: next_st.ecc_vendor = 1'b1;
                afd_pkg::FEA_ECC_FOUR:   next_st.ecc_vendor = 1'b0;
                afd_pkg::FEA_LA_OFF:     next_st.look_ahead = 1'b0;
                afd_pkg::FEA_LA_ON:      next_st.look_ahead = 1'b1;
                afd_pkg::FEA_KEEP_ON:    next_st.keep = 1'b1;
                afd_pkg::FEA_KEEP_OFF:   next_st.keep = 1'b0;
                afd_pkg::FEA_NOP_A, afd_pkg::FEA_NOP_B, afd_pkg::FEA_LEGACY: begin
                  next_st.done = 1'b1;
                end
                afd_pkg::FEA_HOST_CUR:   next_st.host_cur = st.seccnt;
                afd_pkg::FEA_WCACHE_ON: begin
                  if (HAS_WCACHE) next_st.wcache = 1'b1;
                  else begin
                    next_st.err   = 1'b1;
                    next_st.abort = 1'b1;
                  end
                end
                afd_pkg::FEA_WCACHE_OFF: begin
                  if (HAS_WCACHE) begin
                    // stop caching now; completion waits on the media flush
                    next_st.wcache    = 1'b0;
                    next_st.flush_req = 1'b1;
                    next_st.busy      = 1'b1;
                    next_st.done      = 1'b0;
                    next_st.fsm       = FSM_FLUSH;
                  end else begin
                    next_st.err   = 1'b1;
                    next_st.abort = 1'b1;
                  end
                end
                afd_pkg::FEA_XFER_MODE: begin
                  // modes are held as numbers, so one of each is always chosen
                  case (st.seccnt[7:afd_pkg::XFER_TYPE_LSB])
                    afd_pkg::XFER_PIO_DEF: next_st.pio = afd_pkg::RST_PIO;
                    afd_pkg::XFER_PIO: begin
                      if (int'(st.seccnt[2:0]) <= MAX_PIO) next_st.pio = st.seccnt[2:0];
                      else begin
                        next_st.err   = 1'b1;
                        next_st.abort = 1'b1;
                      end
                    end
                    afd_pkg::XFER_MDMA: begin
                      if (HAS_DMA && int'(st.seccnt[2:0]) <= MAX_MDMA) begin
                        next_st.mdma = st.seccnt[2:0];
                      end else begin
                        next_st.err   = 1'b1;
                        next_st.abort = 1'b1;
                      end
                    end
                    default: begin
                      next_st.err   = 1'b1;
                      next_st.abort = 1'b1;
                    end
                  endcase
                end
                default: begin
                  next_st.err   = 1'b1;
                  next_st.abort = 1'b1;
                end
              endcase
            end
            afd_pkg::CMD_SET_MULTIPLE: next_st.multi = st.seccnt;
            afd_pkg::CMD_SLEEP_A, afd_pkg::CMD_SLEEP_B: begin
              next_st.sleep   = 1'b1;
              next_st.standby = 1'b0;
            end
            afd_pkg::CMD_STANDBY_A, afd_pkg::CMD_STANDBY_B: begin
              next_st.standby = 1'b1;
              next_st.sleep   = 1'b0;
            end
            default: begin
              next_st.err   = 1'b1;
              next_st.abort = 1'b1;
            end
          endcase
        end
      end
      FSM_FLUSH: begin
        if (flush_done) begin
          next_st.flush_req = 1'b0;
          next_st.busy      = 1'b0;
          next_st.done      = 1'b1;
          next_st.fsm       = FSM_IDLE;
        end
      end
      // idle must not undo a command write that armed execution above
      FSM_IDLE: ;
      default: next_st.fsm = FSM_IDLE;
    endcase

    // soft reset wakes the card; defaults return unless 66h is in force
    if (soft_reset_req) begin
      next_st.sleep   = 1'b0;
      next_st.standby = 1'b0;
      if (!st.keep) begin
        next_st.eight_bit  = 1'b0;
        next_st.apm        = 1'b0;
        next_st.ext_pwr    = 1'b0;
        next_st.pl1        = 1'b0;
        next_st.ecc_vendor = 1'b0;
        next_st.look_ahead = afd_pkg::RST_LA;
        next_st.pio        = afd_pkg::RST_PIO;
        next_st.mdma       = afd_pkg::RST_MDMA;
        // a cache with unflushed data is not dropped here
        if (st.fsm != FSM_FLUSH) next_st.wcache = afd_pkg::RST_WCACHE;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= ST_RST;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // outputs
  assign s_axi_awready       = st.awready;
  assign s_axi_wready        = st.wready;
  assign s_axi_bvalid        = st.bvalid;
  assign s_axi_bresp         = st.bresp;
  assign s_axi_arready       = st.arready;
  assign s_axi_rvalid        = st.rvalid;
  assign s_axi_rdata         = st.rdata;
  assign s_axi_rresp         = st.rresp;
  assign wide_io_indicator_n = st.wide_io_n;
  assign eight_bit_mode      = st.eight_bit;
  assign write_cache_on      = st.wcache;
  assign flush_req           = st.flush_req;
  assign apm_on              = st.apm;
  assign ext_power_on        = st.ext_pwr;
  assign power_level1_on     = st.pl1;
  assign ecc_vendor_len      = st.ecc_vendor;
  assign look_ahead_on       = st.look_ahead;
  assign pio_mode            = st.pio;
  assign mdma_mode           = st.mdma;
  assign host_current        = st.host_cur;
  assign multiple_count      = st.multi;
  assign sleep_mode          = st.sleep;
  assign standby_mode        = st.standby;
  assign cmd_busy            = st.busy;

  // ==========================================================================
  // assertions
  logic exec_hit;
  logic [15:0] cfg_vec;
  assign exec_hit = ce && st.fsm == FSM_EXEC && st.devhead[afd_pkg::DRIVE_BIT] == DRIVE_SEL
                    && !soft_reset_req;
  assign cfg_vec = {st.eight_bit, st.wcache, st.apm, st.ext_pwr, st.pl1, st.ecc_vendor,
                    st.look_ahead, st.keep, 2'b00, st.pio, st.mdma};

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  byte_lane_a: assert property (ce && st.eight_bit |=> wide_io_indicator_n)
    else $error("wide indicator active in 8-bit mode");
  wide_back_a: assert property (ce && !st.eight_bit && data_reg_access
    |=> !wide_io_indicator_n)
    else $error("wide indicator missing in 16-bit mode");
  cache_on_a: assert property (exec_hit && st.command == afd_pkg::CMD_SET_FEATURES
    && st.feature == afd_pkg::FEA_WCACHE_ON |=> write_cache_on == HAS_WCACHE)
    else $error("write cache not enabled");
  flush_done_a: assert property (flush_req && !flush_done |=> cmd_busy && !st.done)
    else $error("command completed before flush");
  pio_range_a: assert property (int'(pio_mode) <= MAX_PIO && int'(mdma_mode) <= MAX_MDMA)
    else $error("transfer mode out of range");
  apm_set_a: assert property (exec_hit && st.command == afd_pkg::CMD_SET_FEATURES
    && st.feature == afd_pkg::FEA_APM_ON |=> apm_on && st.done)
    else $error("power management not enabled");
  la_off_a: assert property (exec_hit && st.command == afd_pkg::CMD_SET_FEATURES
    && st.feature == afd_pkg::FEA_LA_OFF |=> !look_ahead_on)
    else $error("look-ahead still enabled");
  multi_set_a: assert property (exec_hit && st.command == afd_pkg::CMD_SET_MULTIPLE
    |=> multiple_count == $past(st.seccnt))
    else $error("multiple count not taken");
  sleep_enter_a: assert property (exec_hit && (st.command == afd_pkg::CMD_SLEEP_A
    || st.command == afd_pkg::CMD_SLEEP_B) |=> sleep_mode && !standby_mode)
    else $error("sleep not entered");
  abort_keep_a: assert property (exec_hit && st.command == afd_pkg::CMD_SET_FEATURES
    && st.feature == 8'h00 |=> st.abort && st.err && $stable(cfg_vec))
    else $error("bad feature not aborted cleanly");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");

  flush_seen_c: cover property (flush_req ##[1:20] !flush_req);
  abort_seen_c: cover property (exec_hit ##1 st.abort);
  sleep_seen_c: cover property ($rose(sleep_mode));
  byte_seen_c: cover property ($rose(eight_bit_mode));
endmodule

// ===== inc/afd_pkg.sv
/*
 * constants for the feature and power command decoder: register indexes,
 * command and feature codes, field positions and reset values.
 * assumes a 32-bit axi4-lite bus; each index sits at byte address index*4.
 */
package afd_pkg;
  // ==========================================================================
  // register indexes (byte address = index * 4)
  localparam logic [5:0] IDX_FEATURE  = 6'h01;
  localparam logic [5:0] IDX_SECCNT   = 6'h02;
  localparam logic [5:0] IDX_SECNUM   = 6'h03;
  localparam logic [5:0] IDX_CYL_LO   = 6'h04;
  localparam logic [5:0] IDX_CYL_HI   = 6'h05;
  localparam logic [5:0] IDX_DEVHEAD  = 6'h06;
  localparam logic [5:0] IDX_COMMAND  = 6'h07;
  localparam logic [5:0] IDX_STATUS   = 6'h08;
  localparam logic [5:0] IDX_CONFIG   = 6'h09;
  localparam logic [5:0] IDX_MODES    = 6'h0a;

  // ==========================================================================
  // command codes
  localparam logic [7:0] CMD_SET_FEATURES = 8'hef;
  localparam logic [7:0] CMD_SET_MULTIPLE = 8'hc6;
  localparam logic [7:0] CMD_SLEEP_A      = 8'h99;
  localparam logic [7:0] CMD_SLEEP_B      = 8'he6;
  localparam logic [7:0] CMD_STANDBY_A    = 8'h96;
  localparam logic [7:0] CMD_STANDBY_B    = 8'he2;

  // ==========================================================================
  // feature codes
  localparam logic [7:0] FEA_8BIT_ON    = 8'h01;
  localparam logic [7:0] FEA_WCACHE_ON  = 8'h02;
  localparam logic [7:0] FEA_XFER_MODE  = 8'h03;
  localparam logic [7:0] FEA_APM_ON     = 8'h05;
  localparam logic [7:0] FEA_EXTPWR_ON  = 8'h09;
  localparam logic [7:0] FEA_PL1_ON     = 8'h0a;
  localparam logic [7:0] FEA_ECC_VENDOR = 8'h44;
  localparam logic [7:0] FEA_LA_OFF     = 8'h55;
  localparam logic [7:0] FEA_KEEP_ON    = 8'h66;
  localparam logic [7:0] FEA_NOP_A      = 8'h69;
  localparam logic [7:0] FEA_8BIT_OFF   = 8'h81;
  localparam logic [7:0] FEA_WCACHE_OFF = 8'h82;
  localparam logic [7:0] FEA_APM_OFF    = 8'h85;
  localparam logic [7:0] FEA_EXTPWR_OFF = 8'h89;
  localparam logic [7:0] FEA_PL1_OFF    = 8'h8a;
  localparam logic [7:0] FEA_NOP_B      = 8'h96;
  localparam logic [7:0] FEA_LEGACY     = 8'h97;
  localparam logic [7:0] FEA_HOST_CUR   = 8'h9a;
  localparam logic [7:0] FEA_LA_ON      = 8'haa;
  localparam logic [7:0] FEA_ECC_FOUR   = 8'hbb;
  localparam logic [7:0] FEA_KEEP_OFF   = 8'hcc;

  // transfer type in sector count bits 7:3, mode in bits 2:0
  localparam logic [4:0] XFER_PIO_DEF = 5'h00;
  localparam logic [4:0] XFER_PIO     = 5'h01;
  localparam logic [4:0] XFER_MDMA    = 5'h04;
  localparam int         XFER_TYPE_LSB = 3;
  localparam int         DRIVE_BIT     = 4;

  // ==========================================================================
  // readback field positions
  localparam int ST_BUSY  = 0;
  localparam int ST_ERR   = 1;
  localparam int ST_ABORT = 2;
  localparam int ST_DONE  = 3;
  localparam int ST_FLUSH = 4;
  localparam int ST_SLEEP = 5;
  localparam int ST_STBY  = 6;
  localparam int CF_8BIT  = 0;
  localparam int CF_WC    = 1;
  localparam int CF_APM   = 2;
  localparam int CF_EXT   = 3;
  localparam int CF_PL1   = 4;
  localparam int CF_ECCV  = 5;
  localparam int CF_LA    = 6;
  localparam int CF_KEEP  = 7;
  localparam int MD_PIO   = 0;
  localparam int MD_MDMA  = 4;
  localparam int MD_HCUR  = 8;
  localparam int MD_MULTI = 16;

  // ==========================================================================
  // reset values
  localparam logic       RST_WCACHE = 1'b0;
  localparam logic       RST_LA     = 1'b1;
  localparam logic [2:0] RST_PIO    = 3'h0;
  localparam logic [2:0] RST_MDMA   = 3'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== test/afd_host.sv
/* host model: axi4-lite master for the task-file registers.
   assumes each task is entered right after a rising aclk edge. */
`timescale 1ns/1ps
module afd_host (
  input  wire logic        aclk,
  input  wire logic        s_axi_awready, s_axi_wready, s_axi_arready,
  input  wire logic        s_axi_bvalid, s_axi_rvalid,
  input  wire logic [1:0]  s_axi_bresp, s_axi_rresp,
  input  wire logic [31:0] s_axi_rdata,
  output logic [7:0]       s_axi_awaddr, s_axi_araddr,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_awvalid, s_axi_wvalid, s_axi_bready,
  output logic             s_axi_arvalid, s_axi_rready
);
  // ====
  // bus tasks
  initial {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
  initial {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
  // handshakes read at the falling edge: same value the next rising edge takes, no race
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic ah, wh, bh;
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, 24'h000000, d, 4'h1};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(negedge aclk);
      {ah, wh, bh, r} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
      @(posedge aclk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
    end while (!bh);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, rv;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    do begin
      @(negedge aclk);
      {ar, rv, d, r} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end while (!rv);
  endtask
endmodule

// ===== test/afd_decoder_tb.sv
/* bench for the decoder: host model drives the bus, one task per scenario.
   assumes default decoder parameters. */
`timescale 1ns/1ps
module afd_decoder_tb;
  // ====
  // signals
  logic        aclk = 1'b0, aresetn = 1'b0, data_reg_access = 1'b0, flush_done = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        soft_reset_req = 1'b0;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv, cfg;
  logic [3:0]  s_axi_wstrb;
  logic        wide_io_indicator_n, write_cache_on, flush_req, sleep_mode, standby_mode, cmd_busy;
  int          err_total = 0, check_count = 0, cyc = 0;
  // {feature, value, config bit}
  localparam logic [11:0] FT [14] = '{12'h018, 12'h810, 12'h029, 12'h05a, 12'h852, 12'h09b,
    12'h893, 12'h0ac, 12'h8a4, 12'h44d, 12'hbb5, 12'h556, 12'haae, 12'h66f};
  always #12.5 aclk = ~aclk;
  afd_host afd_host_inst (.aclk, .s_axi_awready, .s_axi_wready, .s_axi_arready, .s_axi_bvalid,
    .s_axi_rvalid, .s_axi_bresp, .s_axi_rresp, .s_axi_rdata, .s_axi_awaddr, .s_axi_araddr,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_awvalid, .s_axi_wvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_rready);
  afd_decoder afd_decoder_inst (.aclk, .aresetn, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .data_reg_access, .flush_done,
    .soft_reset_req, .wide_io_indicator_n, .eight_bit_mode(), .write_cache_on, .flush_req,
    .apm_on(), .ext_power_on(), .power_level1_on(), .ecc_vendor_len(), .look_ahead_on(),
    .pio_mode(), .mdma_mode(), .host_current(), .multiple_count(), .sleep_mode, .standby_mode,
    .cmd_busy);
  // ====
  // helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    afd_host_inst.rd(a, rv, rs);
    chk(rv, e);
  endtask
  task automatic look(ref logic s, input logic e);
    @(negedge aclk);
    chk(s, e);
    @(posedge aclk);
  endtask
  task automatic srst;
    soft_reset_req <= 1'b1;
    @(posedge aclk);
    soft_reset_req <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] f, input logic [7:0] n, input logic [7:0] c);
    afd_host_inst.wr(8'h04, f, rs);
    afd_host_inst.wr(8'h08, n, rs);
    afd_host_inst.wr(8'h1c, c, rs);
  endtask
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ====
  // scenarios
  task automatic t_feat;
    logic [7:0] nf [4] = '{8'h69, 8'h96, 8'h97, 8'h00};
    foreach (FT[i]) begin
      cmd(FT[i][11:4], 8'h00, 8'hef);
      afd_host_inst.rd(8'h24, cfg, rs);
      chk(cfg[FT[i][2:0]], FT[i][3]);
      rdc(8'h20, 32'h8);
    end
    cmd(8'h01, 8'h00, 8'hef);
    data_reg_access <= 1'b1;
    @(posedge aclk);
    look(wide_io_indicator_n, 1'b1);
    cmd(8'h81, 8'h00, 8'hef);
    // indicator follows the mode one edge after execution
    @(posedge aclk);
    look(wide_io_indicator_n, 1'b0);
    data_reg_access <= 1'b0;
    foreach (nf[i]) begin
      cmd(nf[i], 8'h00, 8'hef);
      rdc(8'h24, cfg);
      rdc(8'h20, i == 3 ? 32'he : 32'h8);
    end
    $display("test features done");
  endtask
  task automatic t_mode;
    cmd(8'h03, 8'h0c, 8'hef);
    cmd(8'h03, 8'h22, 8'hef);
    cmd(8'h03, 8'h0f, 8'hef);
    rdc(8'h20, 32'he);
    cmd(8'h9a, 8'h5a, 8'hef);
    cmd(8'h00, 8'h10, 8'hc6);
    rdc(8'h28, 32'h105a24);
    $display("test modes done");
  endtask
  task automatic t_flush;
    cmd(8'h82, 8'h00, 8'hef);
    look(flush_req, 1'b1);
    look(cmd_busy, 1'b1);
    flush_done <= 1'b1;
    @(posedge aclk);
    flush_done <= 1'b0;
    rdc(8'h20, 32'h8);
    look(write_cache_on, 1'b0);
    $display("test flush done");
  endtask
  task automatic t_pwr;
    logic [11:0] pw [4] = '{12'h992, 12'he62, 12'h961, 12'he21};
    foreach (pw[i]) begin
      cmd(8'h00, 8'h00, pw[i][11:4]);
      look(sleep_mode, pw[i][1]);
      look(standby_mode, pw[i][0]);
    end
    afd_host_inst.wr(8'h00, 8'h55, rs);
    chk(rs, 2'h2);
    rdc(8'h30, 32'h0);
    chk(rs, 2'h2);
    rdc(8'h04, 32'h0);
    // other drive: command is dropped, standby stays
    afd_host_inst.wr(8'h18, 8'h10, rs);
    cmd(8'h00, 8'h00, 8'h99);
    rdc(8'h20, 32'h40);
    afd_host_inst.wr(8'h18, 8'h00, rs);
    cmd(8'h05, 8'h00, 8'hef);
    srst();
    look(standby_mode, 1'b0);
    rdc(8'h24, 32'hc4);
    cmd(8'hcc, 8'h00, 8'hef);
    srst();
    rdc(8'h24, 32'h40);
    $display("test power and bus done");
  endtask
  // ====
  // main
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_feat();
    t_mode();
    t_flush();
    t_pwr();
    print_verdict();
  end
endmodule
